/* hdl/dram_ctl_pkg.sv */
// Purpose: constants and types for the 1K x 1 dynamic RAM controller
// Assumes: 250 MHz system clock, pins synchronous to it
// Notes: times are in ns (refresh interval in ms), counts derived below
// Behaviour
// - Refresh is 32 reads over five low bits
// - All refresh reads complete within every 2 ms
// - Strobe inactive means standby, data retained
// - Single strobe times cycles, no precharge clock
// - Device responds only while strobe asserted
// - Write pulse 210 to 500 ns after strobe
package dram_ctl_pkg;

  localparam int CLK_PERIOD_NS = 4;
  localparam int ADDR_W        = 10;
  localparam int ROW_W         = 5;
  localparam int REFRESH_ROWS  = 32;

  // Published timings, ns, refresh interval in ms
  localparam int T_CE_ON_MIN_NS  = 210;
  localparam int T_CE_ON_MAX_NS  = 500;
  localparam int T_CE_OFF_MIN_NS = 230;
  localparam int T_CW_MIN_NS     = 210;
  localparam int T_WP_MIN_NS     = 50;
  localparam int T_CO_MAX_NS     = 185;
  localparam int T_REF_MS        = 2;

  // Least times and the output delay round up, strobe maximum rounds down
  localparam int CE_ON_CYC  = (T_CE_ON_MIN_NS + T_WP_MIN_NS + 20 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_OFF_CYC = (T_CE_OFF_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CW_CYC     = (T_CW_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CO_CYC     = (T_CO_MAX_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CE_MAX_CYC = T_CE_ON_MAX_NS / CLK_PERIOD_NS;
  localparam int WP_CYC     = (T_WP_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Write pulse opens at the earliest legal delay and lasts its least width
  localparam int WR_START_CYC = CW_CYC;
  localparam int WR_END_CYC   = CW_CYC + WP_CYC;
  // One row per slot so all 32 rows fit in the interval
  localparam int REF_SLOT_CYC = (T_REF_MS * 1000000 / CLK_PERIOD_NS) / REFRESH_ROWS / 2;
  localparam int TIMER_W      = 16;

  typedef enum logic [1:0] {ST_IDLE, ST_ON, ST_OFF} cyc_state_t;

  typedef struct packed {
    logic              write;
    logic [ADDR_W-1:0] addr;
    logic              wdata;
  } host_req_t;

  typedef struct packed {
    logic              ce;
    logic              rw_n;
    logic [ADDR_W-1:0] addr;
    logic              din;
  } ram_pins_t;

endpackage

/* hdl/dram_ctl.sv */
// Purpose: host-side controller driving a 1K x 1 dynamic RAM by one strobe
// Assumes: dout from the RAM is synchronous to clk_sys
// Notes: refresh has priority over host requests
`timescale 1ns/1ps
module dram_ctl
  import dram_ctl_pkg::*;
#(
  parameter int REF_SLOT = REF_SLOT_CYC
)
(
  // Clock and reset
  input  wire logic      clk_sys,
  input  wire logic      nrst,
  // Host request
  input  wire host_req_t req,
  input  wire logic      req_valid,
  output logic           req_ready,
  output logic           rd_valid,
  output logic           rd_data,
  // RAM pins
  output ram_pins_t      pins,
  input  wire logic      ram_dout
);

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Timer sits on the last cycle of a phase n cycles long
  function automatic logic last_cycle(input logic [TIMER_W-1:0] t, input int n);
    last_cycle = (t == TIMER_W'(n - 1));
  endfunction

  // Timer lies in the half-open span [lo, hi)
  function automatic logic in_span(input logic [TIMER_W-1:0] t, input int lo, input int hi);
    in_span = (t >= TIMER_W'(lo)) && (t < TIMER_W'(hi));
  endfunction

  // One-cycle advance; callers clear the count at their end point, except ST_OFF, cleared at the next start
  function automatic logic [TIMER_W-1:0] step(input logic [TIMER_W-1:0] t);
    step = t + TIMER_W'(1);
  endfunction

  ////////////////////////////////////////////////////////////////
  // State

  cyc_state_t             state;
  cyc_state_t             next_state;
  logic [TIMER_W-1:0]     timer;
  logic [TIMER_W-1:0]     next_timer;
  logic [TIMER_W-1:0]     ref_timer;
  logic                   ref_pending;
  logic [ROW_W-1:0]       ref_row;
  logic                   cur_refresh;
  logic                   cur_write;
  // Decoded conditions
  logic                   ref_tick;
  logic                   idle;
  logic                   strobe_on;
  logic                   strobe_off;
  logic                   start_ref;
  logic                   start_req;
  logic                   start;
  logic                   on_end;
  logic                   off_end;
  logic                   wr_pulse;
  logic                   sample;
  // Next values of the registered outputs
  logic                   next_ce;
  logic                   next_rw_n;
  logic [ADDR_W-1:0]      ref_addr;
  logic [ADDR_W-1:0]      next_addr;
  logic                   next_din;
  logic                   next_ready;

  ////////////////////////////////////////////////////////////////
  // Decoding

  assign ref_tick   = last_cycle(ref_timer, REF_SLOT);
  assign idle       = (state == ST_IDLE);
  assign strobe_on  = (state == ST_ON);
  assign strobe_off = (state == ST_OFF);
  assign start_ref  = idle && ref_pending;
  // Taken only where ready showed, so a request held high starts once
  assign start_req  = idle && !ref_pending && req_valid && req_ready;
  assign start      = start_ref || start_req;
  assign on_end     = strobe_on && last_cycle(timer, CE_ON_CYC);
  assign off_end    = strobe_off && last_cycle(timer, CE_OFF_CYC);
  assign wr_pulse   = strobe_on && cur_write && in_span(timer, WR_START_CYC, WR_END_CYC);
  // Output delay has run out well before the strobe ends
  assign sample     = strobe_on && !cur_write && !cur_refresh && (timer == TIMER_W'(CO_CYC));

  ////////////////////////////////////////////////////////////////
  // Next values of the pins and the host outputs

  assign next_ce    = start || (strobe_on && !on_end);
  assign next_rw_n  = !wr_pulse;
  assign ref_addr   = {{(ADDR_W-ROW_W){1'b0}}, ref_row};
  assign next_addr  = start_ref ? ref_addr : (start_req ? req.addr : pins.addr);
  assign next_din   = start_req ? req.wdata : pins.din;
  assign next_ready = idle && !ref_pending && !ref_tick && !start_req;

  ////////////////////////////////////////////////////////////////
  // Cycle sequencer; the strobe alone times each access

  always_comb
  begin
    next_state = state;
    next_timer = timer;
    case (state)
      ST_IDLE:
        if (start)
        begin
          next_state = ST_ON;
          next_timer = '0;
        end
      ST_ON:
        if (on_end)
        begin
          next_state = ST_OFF;
          next_timer = '0;
        end
        else
          next_timer = step(timer);
      ST_OFF:
        if (off_end)
          next_state = ST_IDLE;
        else
          next_timer = step(timer);
      default:
      begin
        next_state = ST_IDLE;
        next_timer = '0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      state <= ST_IDLE;
    else
      state <= next_state;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      timer <= '0;
    else
      timer <= next_timer;

  // Kind of the running cycle, fixed when it starts
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      cur_refresh <= 1'b0;
      cur_write   <= 1'b0;
    end
    else if (start)
    begin
      cur_refresh <= start_ref;
      cur_write   <= start_req && req.write;
    end

  ////////////////////////////////////////////////////////////////
  // Refresh

  // Free-running slot timer; a slot missed while busy is not queued twice
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      ref_timer <= '0;
    else
      ref_timer <= ref_tick ? '0 : step(ref_timer);

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      ref_pending <= 1'b0;
    else if (ref_tick)
      ref_pending <= 1'b1;
    else if (start_ref)
      ref_pending <= 1'b0;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      ref_row <= '0;
    else if (start_ref)
      ref_row <= ref_row + ROW_W'(1);

  ////////////////////////////////////////////////////////////////
  // Pin drive; address held for the whole strobe, beyond the hold minimum

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      pins <= '{ce: 1'b0, rw_n: 1'b1, addr: '0, din: 1'b0};
    else
      pins <= '{ce: next_ce, rw_n: next_rw_n, addr: next_addr, din: next_din};

  ////////////////////////////////////////////////////////////////
  // Host side

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      req_ready <= 1'b0;
    else
      req_ready <= next_ready;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      rd_valid <= 1'b0;
    else
      rd_valid <= sample;

  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      rd_data <= 1'b0;
    else if (sample)
      rd_data <= ram_dout;

endmodule

/* bench/dram_ctl_checker.sv */
// Purpose: strobe timing checks
// Assumes: 4 ns clock
// Notes: c counts cycles since ce moved
`timescale 1ns/1ps
module dram_ctl_checker
  import dram_ctl_pkg::*;
(
  input wire logic      clk_sys,
  input wire logic      nrst,
  input wire logic      req_ready,
  input wire ram_pins_t pins
);
  logic pce;
  int   c;
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
      {pce, c} <= {1'h0, 32'h64};
    else
      {pce, c} <= {pins.ce, (pins.ce != pce) ? 32'h0 : c + 32'h1};
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_on_min: assert property (!pins.ce && pce |-> c >= 52) else $error("ce short");
  a_on_max: assert property (pins.ce && pce |-> c <= 123) else $error("ce long");
  a_off_min: assert property (pins.ce && !pce |-> c >= 57) else $error("off short");
  a_wr_delay: assert property ($fell(pins.rw_n) |-> c inside {[52:124]}) else $error("rw delay");
  a_wr_inside: assert property (!pins.rw_n |-> pins.ce && pce) else $error("rw outside");
  a_addr_held: assert property (pins.ce && pce |-> $stable(pins.addr)) else $error("addr moved");
  a_host_stall: assert property (pins.ce |-> !req_ready) else $error("ready in cycle");
  cover property ($fell(pins.rw_n));
  cover property (pins.ce && !pce && pins.addr[9:5] == 5'h0);
  cover property ($rose(req_ready));
endmodule

/* bench/ram_model.sv */
// Purpose: 1K x 1 RAM model
// Assumes: pins sampled on clk_sys
// Notes: lost marks a row left unrefreshed
`timescale 1ns/1ps
module ram_model
  import dram_ctl_pkg::*;
#(
  parameter int LIMIT = 12800
)
(
  input wire logic      clk_sys,
  input wire ram_pins_t pins,
  output logic          ram_dout,
  output logic          lost = 1'h0
);
  logic [ADDR_W-1:0] a = '0;
  logic              pce = 1'h0;
  logic              mem [1024] = '{default: 1'h0};
  int                now = 0;
  int                seen [REFRESH_ROWS] = '{default: 0};
  always @(posedge clk_sys)
  begin
    now <= now + 1;
    pce <= pins.ce;
    if (pins.ce && !pce)
      {a, seen[pins.addr[ROW_W-1:0]]} <= {pins.addr, now};
    if (pins.ce && pce && !pins.rw_n)
      mem[a] <= pins.din;
    foreach (seen[i])
      if (now - seen[i] > LIMIT)
        lost <= 1'h1;
  end
  assign ram_dout = (pins.ce && pce) ? mem[a] : ~mem[a];
endmodule

/* bench/test_dynamic_ram_1k_by_1_access.sv */
// Purpose: access and refresh test
// Assumes: REF_SLOT 200
// Notes: reads checked in order
`timescale 1ns/1ps
module test_dynamic_ram_1k_by_1_access
  import dram_ctl_pkg::*;
;
  logic      clk_sys, nrst = 1'h0, req_valid = 1'h0, req_ready, rd_valid, rd_data, ram_dout, lost, e;
  host_req_t req = '0;
  ram_pins_t pins;
  logic      shadow [1024] = '{default: 1'h0};
  logic      exp_q [$];
  int        bad_count = 0, tests_run = 0, seed = 83285;
  dram_ctl #(.REF_SLOT(200)) dram_ctl_inst (.clk_sys(clk_sys), .nrst(nrst), .req(req), .req_valid(req_valid),
    .req_ready(req_ready), .rd_valid(rd_valid), .rd_data(rd_data), .pins(pins), .ram_dout(ram_dout));
  ram_model #(.LIMIT(12800)) ram_model_inst (.clk_sys(clk_sys), .pins(pins), .ram_dout(ram_dout), .lost(lost));
  initial
  begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic test_done();
    if (bad_count == 0 && tests_run > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  function automatic int xorshift(input int s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic access(input logic w, input logic [ADDR_W-1:0] a, input logic d);
    int n = 0;
    req <= '{w, a, d};
    req_valid <= 1'h1;
    do
      @(posedge clk_sys);
    while (req_ready !== 1'h1 && ++n < 400);
    req_valid <= 1'h0;
    bad_count += (n >= 400);
    if (n >= 400)
      test_done();
    if (w)
      shadow[a] = d;
    else
      exp_q.push_back(shadow[a]);
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys)
    if (rd_valid === 1'h1)
    begin
      tests_run++;
      e = exp_q.size() ? exp_q.pop_front() : 1'hx;
      if (rd_data !== e)
      begin
        bad_count++;
        $display("MISMATCH rd_data exp %b seen %b", e, rd_data);
      end
    end
  initial
  begin
    repeat (3) @(posedge clk_sys);
    nrst <= 1'h1;
    @(posedge clk_sys);
    for (int i = 0; i < 48; i++)
    begin
      seed = xorshift(seed);
      access(1'h1, (i < 2) ? {ADDR_W{i[0]}} : seed[ADDR_W-1:0], seed[20]);
      access(1'h0, (i < 2) ? {ADDR_W{i[0]}} : seed[ADDR_W-1:0], 1'h0);
      access(1'h0, (i < 2) ? {ADDR_W{i[0]}} : seed[ADDR_W-1:0], 1'h0);
    end
    repeat (60) @(posedge clk_sys);
    tests_run++;
    if (exp_q.size() != 0 || lost !== 1'h0)
    begin
      bad_count++;
      $display("MISMATCH lost exp 0 seen %b", lost);
    end
    test_done();
  end
endmodule
bind dram_ctl dram_ctl_checker dram_ctl_checker_inst (.clk_sys(clk_sys), .nrst(nrst), .req_ready(req_ready), .pins(pins));
